/* core/ibr_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/10ps
`default_nettype none
module ibr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

/* core/ibr_pkg.sv */
// Constants and enumerations for the instrument bus remote/local block.
// Assumes a 200 MHz core clock; bus lines arrive synchronous to it.
package ibr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W = 9;

  // ----------------------------------------------------------------
  // Addressing and interface commands (ATN asserted, parity masked)
  // ----------------------------------------------------------------
  localparam logic [4:0] DEFAULT_BUS_ADDR = 5'h13;
  localparam logic [7:0] CMD_GO_TO_LOCAL = 8'h01;
  localparam logic [7:0] CMD_LOCAL_LOCKOUT = 8'h11;
  localparam logic [7:0] CMD_UNLISTEN = 8'h3F;
  localparam logic [7:0] CMD_UNTALK = 8'h5F;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK = 3'h2;

  // ----------------------------------------------------------------
  // Program code characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_K = 8'h4B;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;

  // ----------------------------------------------------------------
  // Frequency held as 11 BCD digits in hertz
  // ----------------------------------------------------------------
  localparam int FREQ_DIGITS = 11;
  localparam int FREQ_W = 44;
  localparam logic [43:0] FREQ_PRESET = 44'h09000000000;
  localparam logic [3:0] TX_TOP_IDX = 4'hA;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AH_IDLE, AH_NRDY, AH_RDY, AH_ACC} ibr_ah_t;
  typedef enum logic [1:0] {SH_IDLE, SH_LOAD, SH_SETTLE, SH_WACC} ibr_sh_t;
  typedef enum logic [2:0] {PS_IDLE, PS_F, PS_NUM, PS_UNIT, PS_O} ibr_ps_t;
  typedef enum logic [1:0] {TX_DIGITS, TX_CR, TX_LF, TX_DONE} ibr_txph_t;

endpackage

/* core/ibr_top.sv */
// Instrument bus device interface: remote/local, addressing, handshake,
// program code parser and frequency report talker.
// Assumes bus lines sampled synchronously; open-drain resolved outside.
// What this block does
// - REN plus listen address enters remote
// - Go-to-local drops remote unless locked, keeps listen
// - Local key returns to local unless locked
// - Lockout makes local key ignored
// - REN release clears lockout, goes local
// - Listener bytes executed as program codes
// - Frequency query answered as talker digits
// - Bus address defaults to nineteen, configurable
// - Standby forces local, remote indicator off
`timescale 1ns/10ps
`default_nettype none
module ibr_top #(
  parameter logic [4:0] BUS_ADDR = ibr_pkg::DEFAULT_BUS_ADDR,
  parameter int FIFO_DEPTH = ibr_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfg_addr_override,
  input wire logic [4:0] cfg_addr,
  input wire logic local_key_press,
  input wire logic power_standby_position,
  input wire logic exec_ready,
  input wire logic ren_n_in,
  input wire logic atn_n_in,
  input wire logic ifc_n_in,
  input wire logic [7:0] dio_n_in,
  output logic [7:0] dio_n_out,
  output logic [7:0] dio_n_oe,
  input wire logic dav_n_in,
  output logic dav_n_out,
  output logic dav_n_oe,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_n_oe,
  input wire logic ndac_n_in,
  output logic ndac_n_out,
  output logic ndac_n_oe,
  output logic eoi_n_out,
  output logic eoi_n_oe,
  output logic remote_indicator,
  output logic listen_indicator,
  output logic talk_indicator,
  output logic lockout_indicator,
  output logic [43:0] freq_bcd,
  output logic freq_update
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic remote;
    logic listen;
    logic talk;
    logic lockout;
    ibr_pkg::ibr_ah_t ah;
    logic nrfd_oe;
    logic ndac_oe;
    logic [7:0] rx_byte;
    logic rx_push;
    ibr_pkg::ibr_sh_t sh;
    logic dav_oe;
    logic eoi_oe;
    logic [7:0] dio_oe;
    logic [8:0] settle_cnt;
    logic [3:0] tx_idx;
    ibr_pkg::ibr_txph_t tx_phase;
    logic tx_seen;
    logic tx_pend;
    logic [43:0] tx_digits;
    ibr_pkg::ibr_ps_t ps;
    logic [43:0] acc;
    logic [7:0] unit;
    logic [43:0] freq;
    logic freq_upd;
  } ibr_state_t;

  ibr_state_t s_q;
  ibr_state_t s_d;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic parse_take;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_digit(input logic [7:0] c);
    return (c >= ibr_pkg::CH_0) && (c <= ibr_pkg::CH_9);
  endfunction

  function automatic logic [43:0] scale_by_unit(input logic [43:0] v, input logic [7:0] u);
    unique case (u)
      ibr_pkg::CH_G: return v << 36;
      ibr_pkg::CH_M: return v << 24;
      ibr_pkg::CH_K: return v << 12;
      default: return v;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Received data buffer
  // ----------------------------------------------------------------
  ibr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(s_q.rx_push),
    .in_ready(fifo_in_ready),
    .in_data(s_q.rx_byte),
    .out_valid(fifo_out_valid),
    .out_ready(parse_take),
    .out_data(fifo_out_data)
  );

  assign parse_take = fifo_out_valid && exec_ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic atn;
    logic ren;
    logic [4:0] addr;
    logic [7:0] cmd;
    logic [7:0] bus_byte;
    logic ah_active;
    logic [3:0] dig;
    logic [7:0] tx_byte;
    atn = !atn_n_in;
    ren = !ren_n_in;
    addr = cfg_addr_override ? cfg_addr : BUS_ADDR;
    bus_byte = ~dio_n_in;
    cmd = {1'b0, bus_byte[6:0]};
    ah_active = atn || s_q.listen;
    dig = s_q.tx_digits[4*s_q.tx_idx +: 4];
    tx_byte = 8'h00;
    s_d = s_q;
    s_d.freq_upd = 1'b0;
    if (s_q.rx_push && fifo_in_ready) begin
      s_d.rx_push = 1'b0;
    end

    // Acceptor handshake
    unique case (s_q.ah)
      ibr_pkg::AH_IDLE: begin
        s_d.nrfd_oe = 1'b0;
        s_d.ndac_oe = 1'b0;
        if (ah_active) begin
          s_d.ah = ibr_pkg::AH_NRDY;
          s_d.nrfd_oe = 1'b1;
          s_d.ndac_oe = 1'b1;
        end
      end
      ibr_pkg::AH_NRDY: begin
        if (!ah_active) begin
          s_d.ah = ibr_pkg::AH_IDLE;
          s_d.nrfd_oe = 1'b0;
          s_d.ndac_oe = 1'b0;
        end else if (atn || (fifo_in_ready && !s_q.rx_push)) begin
          s_d.ah = ibr_pkg::AH_RDY;
          s_d.nrfd_oe = 1'b0;
        end
      end
      ibr_pkg::AH_RDY: begin
        if (!ah_active) begin
          s_d.ah = ibr_pkg::AH_IDLE;
          s_d.ndac_oe = 1'b0;
        end else if (!dav_n_in) begin
          // Byte latched: hold off further data and release accept in the same cycle
          s_d.ah = ibr_pkg::AH_ACC;
          s_d.nrfd_oe = 1'b1;
          s_d.ndac_oe = 1'b0;
          if (atn) begin
            if (cmd == {ibr_pkg::GRP_LISTEN, addr}) begin
              s_d.listen = 1'b1;
              s_d.remote = s_q.remote || ren;
            end else if (cmd == ibr_pkg::CMD_UNLISTEN) begin
              s_d.listen = 1'b0;
            end else if (cmd == {ibr_pkg::GRP_TALK, addr}) begin
              s_d.talk = 1'b1;
              s_d.listen = 1'b0;
            end else if (cmd == ibr_pkg::CMD_UNTALK || cmd[7:5] == ibr_pkg::GRP_TALK) begin
              s_d.talk = 1'b0;
            end else if (cmd == ibr_pkg::CMD_GO_TO_LOCAL && s_q.listen) begin
              s_d.remote = 1'b0;
            end else if (cmd == ibr_pkg::CMD_LOCAL_LOCKOUT && ren) begin
              s_d.lockout = 1'b1;
            end
          end else begin
            s_d.rx_byte = bus_byte;
            s_d.rx_push = 1'b1;
          end
        end
      end
      ibr_pkg::AH_ACC: begin
        if (dav_n_in) begin
          s_d.ah = ibr_pkg::AH_NRDY;
          s_d.ndac_oe = 1'b1;
        end
      end
    endcase

    // Local key, unless locked out
    if (local_key_press && !s_q.lockout) begin
      s_d.remote = 1'b0;
    end
    if (s_q.lockout) begin
      s_d.remote = s_d.remote || (s_q.remote && ren);
    end

    // REN released: local, lockout cleared, addressing kept
    if (!ren) begin
      s_d.remote = 1'b0;
      s_d.lockout = 1'b0;
    end
    if (!ifc_n_in) begin
      s_d.listen = 1'b0;
      s_d.talk = 1'b0;
    end

    // Program code parser
    if (parse_take) begin
      unique case (s_q.ps)
        ibr_pkg::PS_IDLE: begin
          if (fifo_out_data == ibr_pkg::CH_F) begin
            s_d.ps = ibr_pkg::PS_F;
          end else if (fifo_out_data == ibr_pkg::CH_O) begin
            s_d.ps = ibr_pkg::PS_O;
          end
        end
        ibr_pkg::PS_F: begin
          s_d.ps = (fifo_out_data == ibr_pkg::CH_R) ? ibr_pkg::PS_NUM : ibr_pkg::PS_IDLE;
          s_d.acc = '0;
        end
        ibr_pkg::PS_NUM: begin
          if (is_digit(fifo_out_data)) begin
            s_d.acc = {s_q.acc[39:0], fifo_out_data[3:0]};
          end else if (fifo_out_data == ibr_pkg::CH_G || fifo_out_data == ibr_pkg::CH_M ||
                       fifo_out_data == ibr_pkg::CH_K || fifo_out_data == ibr_pkg::CH_H) begin
            s_d.unit = fifo_out_data;
            s_d.ps = ibr_pkg::PS_UNIT;
          end else begin
            s_d.ps = ibr_pkg::PS_IDLE;
          end
        end
        ibr_pkg::PS_UNIT: begin
          if (fifo_out_data == ibr_pkg::CH_Z) begin
            s_d.freq = scale_by_unit(s_q.acc, s_q.unit);
            s_d.freq_upd = 1'b1;
          end
          s_d.ps = ibr_pkg::PS_IDLE;
        end
        ibr_pkg::PS_O: begin
          if (fifo_out_data == ibr_pkg::CH_K) begin
            s_d.tx_pend = 1'b1;
            s_d.tx_digits = s_q.freq;
            s_d.tx_idx = ibr_pkg::TX_TOP_IDX;
            s_d.tx_phase = ibr_pkg::TX_DIGITS;
            s_d.tx_seen = 1'b0;
          end
          s_d.ps = ibr_pkg::PS_IDLE;
        end
        default: s_d.ps = ibr_pkg::PS_IDLE;
      endcase
    end

    // Source handshake: frequency report
    unique case (s_q.tx_phase)
      ibr_pkg::TX_DIGITS: tx_byte = {4'h3, dig};
      ibr_pkg::TX_CR: tx_byte = ibr_pkg::CH_CR;
      ibr_pkg::TX_LF: tx_byte = ibr_pkg::CH_LF;
      ibr_pkg::TX_DONE: tx_byte = 8'h00;
    endcase
    unique case (s_q.sh)
      ibr_pkg::SH_IDLE: begin
        if (s_q.talk && !atn && s_q.tx_pend) begin
          s_d.sh = ibr_pkg::SH_LOAD;
        end
      end
      ibr_pkg::SH_LOAD: begin
        if (s_q.tx_phase == ibr_pkg::TX_DONE) begin
          // A query taken this cycle keeps the report pending
          s_d.tx_pend = (s_d.tx_phase != ibr_pkg::TX_DONE);
          s_d.sh = ibr_pkg::SH_IDLE;
        end else if (s_q.tx_phase == ibr_pkg::TX_DIGITS && !s_q.tx_seen &&
                     dig == 4'h0 && s_q.tx_idx != 4'h0) begin
          s_d.tx_idx = s_q.tx_idx - 4'h1;
        end else begin
          s_d.tx_seen = 1'b1;
          s_d.dio_oe = tx_byte;
          s_d.eoi_oe = (s_q.tx_phase == ibr_pkg::TX_LF);
          s_d.settle_cnt = 9'(ibr_pkg::SETTLE_CYC);
          s_d.sh = ibr_pkg::SH_SETTLE;
        end
      end
      ibr_pkg::SH_SETTLE: begin
        if (s_q.settle_cnt != 9'h000) begin
          s_d.settle_cnt = s_q.settle_cnt - 9'h001;
        end else if (nrfd_n_in) begin
          s_d.dav_oe = 1'b1;
          s_d.sh = ibr_pkg::SH_WACC;
        end
      end
      ibr_pkg::SH_WACC: begin
        if (ndac_n_in) begin
          s_d.dav_oe = 1'b0;
          s_d.dio_oe = 8'h00;
          s_d.eoi_oe = 1'b0;
          s_d.sh = ibr_pkg::SH_LOAD;
          if (s_q.tx_phase == ibr_pkg::TX_DIGITS && s_q.tx_idx != 4'h0) begin
            s_d.tx_idx = s_q.tx_idx - 4'h1;
          end else begin
            s_d.tx_phase = ibr_pkg::ibr_txph_t'(s_q.tx_phase + 2'h1);
          end
        end
      end
    endcase
    if (atn || !s_q.talk) begin
      s_d.sh = ibr_pkg::SH_IDLE;
      s_d.dav_oe = 1'b0;
      s_d.dio_oe = 8'h00;
      s_d.eoi_oe = 1'b0;
    end

    // Standby: back to local with interface state cleared
    if (power_standby_position) begin
      s_d.remote = 1'b0;
      s_d.lockout = 1'b0;
      s_d.listen = 1'b0;
      s_d.talk = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{
        remote: 1'b0,
        listen: 1'b0,
        talk: 1'b0,
        lockout: 1'b0,
        ah: ibr_pkg::AH_IDLE,
        nrfd_oe: 1'b0,
        ndac_oe: 1'b0,
        rx_byte: 8'h00,
        rx_push: 1'b0,
        sh: ibr_pkg::SH_IDLE,
        dav_oe: 1'b0,
        eoi_oe: 1'b0,
        dio_oe: 8'h00,
        settle_cnt: 9'h000,
        tx_idx: 4'h0,
        tx_phase: ibr_pkg::TX_DONE,
        tx_seen: 1'b0,
        tx_pend: 1'b0,
        tx_digits: 44'h00000000000,
        ps: ibr_pkg::PS_IDLE,
        acc: 44'h00000000000,
        unit: 8'h00,
        freq: ibr_pkg::FREQ_PRESET,
        freq_upd: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dio_n_out = 8'h00;
  assign dio_n_oe = s_q.dio_oe;
  assign dav_n_out = 1'b0;
  assign dav_n_oe = s_q.dav_oe;
  assign nrfd_n_out = 1'b0;
  assign nrfd_n_oe = s_q.nrfd_oe;
  assign ndac_n_out = 1'b0;
  assign ndac_n_oe = s_q.ndac_oe;
  assign eoi_n_out = 1'b0;
  assign eoi_n_oe = s_q.eoi_oe;
  assign remote_indicator = s_q.remote;
  assign listen_indicator = s_q.listen;
  assign talk_indicator = s_q.talk;
  assign lockout_indicator = s_q.lockout;
  assign freq_bcd = s_q.freq;
  assign freq_update = s_q.freq_upd;

endmodule
`default_nettype wire

/* verification/ibr_ctrl_model.sv */
// Bus controller model: sends commands and data, listens to the device.
// Drives DIO, DAV, NRFD and NDAC as active-high pull enables over pull-ups; REN, ATN and IFC as direct active-low levels.
`timescale 1ns/10ps
`default_nettype none
module ibr_ctrl_model (
  input wire logic core_clk,
  input wire logic [7:0] dio_n,
  input wire logic dav_n,
  input wire logic nrfd_n,
  input wire logic ndac_n,
  input wire logic eoi_n,
  output logic ren_n,
  output logic atn_n,
  output logic ifc_n,
  output logic [7:0] dio_drv,
  output logic dav_drv,
  output logic nrfd_drv,
  output logic ndac_drv
);
  // ---------------------------------------------------------------
  // Line control, changed at falling edges only
  // ---------------------------------------------------------------
  initial begin
    ren_n = 1'b1;
    atn_n = 1'b1;
    ifc_n = 1'b1;
    dio_drv = 8'h00;
    dav_drv = 1'b0;
    nrfd_drv = 1'b0;
    ndac_drv = 1'b0;
  end
  task automatic set_ren(input logic v);
    @(negedge core_clk);
    ren_n = v;
    repeat (2) @(negedge core_clk);
  endtask
  // Interface clear, one cycle low
  task automatic pulse_ifc();
    @(negedge core_clk);
    ifc_n = 1'b0;
    @(negedge core_clk);
    ifc_n = 1'b1;
  endtask
  // Source side; ATN stays as left for the next byte
  task automatic send(input logic [7:0] b, input logic cmd);
    @(negedge core_clk);
    atn_n = !cmd;
    nrfd_drv = 1'b0;
    ndac_drv = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int n = 0; n < 4000 && nrfd_n !== 1'b1; n++) @(negedge core_clk);
    dio_drv = b;
    repeat (2) @(negedge core_clk);
    dav_drv = 1'b1;
    for (int n = 0; n < 4000 && ndac_n !== 1'b1; n++) @(negedge core_clk);
    dav_drv = 1'b0;
    dio_drv = 8'h00;
  endtask
  // Acceptor side; slow delays the ready release
  task automatic recv(output logic [7:0] b, output logic eoi, input int slow);
    @(negedge core_clk);
    atn_n = 1'b1;
    nrfd_drv = 1'b1;
    ndac_drv = 1'b1;
    repeat (slow) @(negedge core_clk);
    nrfd_drv = 1'b0;
    for (int n = 0; n < 4000 && dav_n !== 1'b0; n++) @(negedge core_clk);
    b = ~dio_n;
    eoi = !eoi_n;
    nrfd_drv = 1'b1;
    ndac_drv = 1'b0;
    for (int n = 0; n < 4000 && dav_n !== 1'b1; n++) @(negedge core_clk);
    ndac_drv = 1'b1;
  endtask
endmodule
`default_nettype wire

/* verification/ibr_top_properties.sv */
// Checker for the instrument bus block: remote/local, acceptor, talker.
// Bound to ibr_top; sees its ports only, single clock domain.
`timescale 1ns/10ps
`default_nettype none
module ibr_top_properties #(
  parameter logic [4:0] BUS_ADDR = ibr_pkg::DEFAULT_BUS_ADDR,
  parameter int FIFO_DEPTH = ibr_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ren_n_in,
  input wire logic atn_n_in,
  input wire logic ifc_n_in,
  input wire logic local_key_press,
  input wire logic power_standby_position,
  input wire logic dav_n_in,
  input wire logic nrfd_n_in,
  input wire logic [7:0] dio_n_oe,
  input wire logic dav_n_oe,
  input wire logic nrfd_n_oe,
  input wire logic ndac_n_oe,
  input wire logic eoi_n_oe,
  input wire logic remote_indicator,
  input wire logic listen_indicator,
  input wire logic talk_indicator,
  input wire logic lockout_indicator,
  input wire logic freq_update
);
  // ---------------------------------------------------------------
  // Cycles since the talker data last changed
  // ---------------------------------------------------------------
  localparam int SETTLE_MIN = ibr_pkg::SETTLE_CYC - 2;
  logic [7:0] dio_prev_q;
  int settle_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dio_prev_q <= 8'h00;
      settle_q <= 0;
    end else begin
      dio_prev_q <= dio_n_oe;
      settle_q <= (dio_n_oe != dio_prev_q) ? 0 : settle_q + 1;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_remote_cause; $rose(remote_indicator) |-> !ren_n_in && listen_indicator; endproperty
  a_remote_cause: assert property (p_remote_cause) else $error("remote without enable");
  property p_local_key; remote_indicator && !lockout_indicator && local_key_press
    |=> !remote_indicator && $stable(listen_indicator); endproperty
  a_local_key: assert property (p_local_key) else $error("local key ignored");
  property p_locked; lockout_indicator && remote_indicator && local_key_press && !ren_n_in
    && !power_standby_position |=> remote_indicator; endproperty
  a_locked: assert property (p_locked) else $error("local key acted under lockout");
  property p_ren_off; ren_n_in |=> !remote_indicator && !lockout_indicator; endproperty
  a_ren_off: assert property (p_ren_off) else $error("remote kept without enable");
  property p_talk_kept; atn_n_in && $past(atn_n_in) && ifc_n_in && $past(ifc_n_in)
    && !power_standby_position && !$past(power_standby_position) |-> $stable(talk_indicator);
  endproperty
  a_talk_kept: assert property (p_talk_kept) else $error("talk changed without command");
  property p_pulse; freq_update |=> !freq_update; endproperty
  a_pulse: assert property (p_pulse) else $error("update pulse too long");
  property p_settle; $rose(dav_n_oe) |-> $past(nrfd_n_in) && talk_indicator
    && settle_q >= SETTLE_MIN; endproperty
  a_settle: assert property (p_settle) else $error("data valid too early");
  property p_standby; power_standby_position |=> !remote_indicator && !listen_indicator
    && !talk_indicator && !lockout_indicator; endproperty
  a_standby: assert property (p_standby) else $error("standby left state");
  property p_take; !nrfd_n_oe && ndac_n_oe && !dav_n_in |=> nrfd_n_oe && !ndac_n_oe; endproperty
  a_take: assert property (p_take) else $error("byte not taken");
  property p_hold; nrfd_n_oe && !ndac_n_oe && !dav_n_in |=> nrfd_n_oe && !ndac_n_oe; endproperty
  a_hold: assert property (p_hold) else $error("acceptor lines dropped early");
  property p_ndac_back; nrfd_n_oe && !ndac_n_oe && dav_n_in |=> ndac_n_oe; endproperty
  a_ndac_back: assert property (p_ndac_back) else $error("not accepted not restored");
  c_take: cover property (!nrfd_n_oe && ndac_n_oe && !dav_n_in);
  c_last: cover property ($rose(dav_n_oe) && eoi_n_oe);
  c_locked_key: cover property (lockout_indicator && local_key_press);
endmodule

bind ibr_top ibr_top_properties #(.BUS_ADDR(BUS_ADDR), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .core_clk, .rst, .ren_n_in, .atn_n_in, .ifc_n_in, .local_key_press, .power_standby_position,
  .dav_n_in, .nrfd_n_in, .dio_n_oe, .dav_n_oe, .nrfd_n_oe, .ndac_n_oe, .eoi_n_oe,
  .remote_indicator, .listen_indicator, .talk_indicator, .lockout_indicator, .freq_update);
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for ibr_top driven by the bus controller model.
// Assumes the model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %0t: got %h want %h", $time, a, e); end end
module testbench;
  // ---------------------------------------------------------------
  // Stimulus and bus wiring
  // ---------------------------------------------------------------
  localparam logic [7:0] MLA = {ibr_pkg::GRP_LISTEN, ibr_pkg::DEFAULT_BUS_ADDR};
  localparam logic [7:0] MTA = {ibr_pkg::GRP_TALK, ibr_pkg::DEFAULT_BUS_ADDR};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ovr = 1'b0;
  logic key = 1'b0;
  logic sby = 1'b0;
  logic exr = 1'b1;
  logic [4:0] cfg_addr = 5'h00;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] dio_oe, dio_drv, rx, ex;
  logic dav_oe, nrfd_oe, ndac_oe, eoi_oe, dav_drv, nrfd_drv, ndac_drv;
  logic ren_n, atn_n, ifc_n, rem, lis, tkr, llo, fupd, eoi;
  logic [43:0] freq;
  logic [7:0] sfx [4] = '{ibr_pkg::CH_G, ibr_pkg::CH_M, ibr_pkg::CH_K, ibr_pkg::CH_H};
  int shf [4] = '{9, 6, 3, 0};
  string rpt = "23456789012";
  wire logic [7:0] dio_n = ~(dio_oe | dio_drv);
  wire logic dav_n = ~(dav_oe | dav_drv);
  wire logic nrfd_n = ~(nrfd_oe | nrfd_drv);
  wire logic ndac_n = ~(ndac_oe | ndac_drv);
  wire logic eoi_n = ~eoi_oe;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  ibr_ctrl_model u_ctrl (.core_clk, .dio_n, .dav_n, .nrfd_n, .ndac_n, .eoi_n, .ren_n, .atn_n,
    .ifc_n, .dio_drv, .dav_drv, .nrfd_drv, .ndac_drv);

  ibr_top u_dut (.core_clk, .rst, .cfg_addr_override(ovr), .cfg_addr, .local_key_press(key),
    .power_standby_position(sby), .exec_ready(exr), .ren_n_in(ren_n), .atn_n_in(atn_n),
    .ifc_n_in(ifc_n), .dio_n_in(dio_n), .dio_n_out(), .dio_n_oe(dio_oe), .dav_n_in(dav_n),
    .dav_n_out(), .dav_n_oe(dav_oe), .nrfd_n_in(nrfd_n), .nrfd_n_out(), .nrfd_n_oe(nrfd_oe),
    .ndac_n_in(ndac_n), .ndac_n_out(), .ndac_n_oe(ndac_oe), .eoi_n_out(), .eoi_n_oe(eoi_oe),
    .remote_indicator(rem), .listen_indicator(lis), .talk_indicator(tkr),
    .lockout_indicator(llo), .freq_bcd(freq), .freq_update(fupd));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] b);
    u_ctrl.send(b, 1'b1);
    idle(4);
  endtask
  task automatic put_str(input string s);
    for (int i = 0; i < s.len(); i++) u_ctrl.send(s[i], 1'b0);
  endtask
  task automatic wait_freq(input logic [43:0] e);
    for (int n = 0; n < 400 && freq !== e; n++) @(negedge core_clk);
    `CHK(freq, e)
    `CHK(fupd, 1'b1)
  endtask
  task automatic press();
    @(negedge core_clk) key = 1'b1;
    @(negedge core_clk) key = 1'b0;
    idle(2);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    idle(2);
    `CHK({rem, lis, tkr, llo}, 4'h0)
    `CHK(freq, ibr_pkg::FREQ_PRESET)
    u_ctrl.set_ren(1'b0);
    cmd(MLA);
    `CHK({rem, lis}, 2'h3)
    cmd(ibr_pkg::CMD_GO_TO_LOCAL);
    `CHK({rem, lis}, 2'h1)
    cmd(MLA);
    press();
    `CHK({rem, lis}, 2'h1)
    cmd(MLA);
    cmd(ibr_pkg::CMD_LOCAL_LOCKOUT);
    press();
    `CHK({rem, llo}, 2'h3)
    for (int i = 0; i < 4; i++) begin
      put_str("FR11");
      u_ctrl.send(sfx[i], 1'b0);
      u_ctrl.send(ibr_pkg::CH_Z, 1'b0);
      wait_freq(44'h11 << (4 * shf[i]));
    end
    // Stalled parser: sixteen bytes fill the buffer, then ready stays low
    @(negedge core_clk) exr = 1'b0;
    put_str("FR123456789012HZ");
    idle(40);
    `CHK({nrfd_oe, nrfd_n}, 2'h2)
    @(negedge core_clk) exr = 1'b1;
    wait_freq(44'h23456789012);
    put_str("OK");
    cmd(ibr_pkg::CMD_UNLISTEN);
    cmd(MTA);
    for (int i = 0; i < 13; i++) begin
      u_ctrl.recv(rx, eoi, (i % 3) * 25);
      ex = (i < 11) ? rpt[i] : ((i == 11) ? ibr_pkg::CH_CR : ibr_pkg::CH_LF);
      `CHK(rx, ex)
    end
    `CHK({eoi, tkr, lis, rem, llo}, 5'h1B)
    u_ctrl.set_ren(1'b1);
    `CHK({rem, llo, tkr}, 3'h1)
    @(negedge core_clk) sby = 1'b1;
    idle(2);
    sby = 1'b0;
    `CHK({rem, lis, tkr, llo}, 4'h0)
    @(negedge core_clk);
    ovr = 1'b1;
    cfg_addr = 5'h05;
    u_ctrl.set_ren(1'b0);
    cmd(MLA);
    `CHK(lis, 1'b0)
    cmd({ibr_pkg::GRP_LISTEN, 5'h05});
    `CHK({rem, lis}, 2'h3)
    // Interface clear drops addressing, remote stays
    u_ctrl.pulse_ifc();
    idle(1);
    `CHK({rem, lis}, 2'h2)
    close_out();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    $display("unexpected %0t: watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
